// file: design/hbfrs_fault_channel.sv
// response state machine and hiccup timer for one protection fault
`timescale 1ns/1ps
`default_nettype none
`include "hbfrs_defs.svh"
module hbfrs_fault_channel import hbfrs_pkg::*; #(
  parameter logic [`HBFRS_TIMER_W-1:0] HICCUP_CYCLES = `HBFRS_HICCUP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // fault and selected response
  input wire logic faultIn,
  input wire logic [1:0] respMode,
  input wire logic toggleSeen,
  // stop request for the next cycle, and current state
  output logic stopNext,
  output hbfrs_state_t state
);
  hbfrs_state_t next_state;
  logic [`HBFRS_TIMER_W-1:0] count;
  logic [`HBFRS_TIMER_W-1:0] next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      HBFRS_IDLE: begin
        if (faultIn) begin
          case (respMode)
            HBFRS_HICCUP: next_state = HBFRS_HOLD;
            HBFRS_LATCH: next_state = HBFRS_LATCHED;
            default: next_state = HBFRS_IDLE;
          endcase
        end
      end
      HBFRS_HOLD: begin
        next_count = `HBFRS_TIMER_ZERO;
        if (!faultIn) next_state = HBFRS_WAIT;
      end
      HBFRS_WAIT: begin
        // a fault that returns during the wait restarts the whole delay
        if (faultIn) begin
          next_state = HBFRS_HOLD;
        end else if (count == HICCUP_CYCLES - `HBFRS_TIMER_ONE) begin
          next_state = HBFRS_IDLE;
        end else begin
          next_count = count + `HBFRS_TIMER_ONE;
        end
      end
      HBFRS_LATCHED: begin
        // a toggle while the fault is still there does not release
        if (toggleSeen && !faultIn) next_state = HBFRS_IDLE;
      end
      default: next_state = HBFRS_IDLE;
    endcase
    stopNext = (next_state != HBFRS_IDLE);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= HBFRS_IDLE;
      count <= `HBFRS_TIMER_ZERO;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  a_flag_stays_idle: assert property (@(posedge clock) disable iff (reset)
    (state == HBFRS_IDLE && faultIn && respMode[1] == respMode[0]) |=> state == HBFRS_IDLE)
    else $error("flag-only response left idle");

  a_hiccup_restart: assert property (@(posedge clock) disable iff (reset)
    (state == HBFRS_WAIT && !faultIn && count == HICCUP_CYCLES - `HBFRS_TIMER_ONE)
    |=> state == HBFRS_IDLE)
    else $error("hiccup did not restart after the delay");

  a_latch_holds: assert property (@(posedge clock) disable iff (reset)
    (state == HBFRS_LATCHED && !toggleSeen) |=> state == HBFRS_LATCHED)
    else $error("latch-off released without a toggle");
endmodule
`default_nettype wire

// file: design/hbfrs_toggle_sense.sv
// edge sensing on the switching-enable and chip-enable pins
`timescale 1ns/1ps
`default_nettype none
module hbfrs_toggle_sense (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // enable pins
  input wire logic switchEnablePin,
  input wire logic chipEnablePin,
  // one-cycle pulse on any edge of either pin
  output logic toggleSeen
);
  logic prevSwitch;
  logic prevChip;
  logic next_prevSwitch;
  logic next_prevChip;
  logic next_toggleSeen;

  always_comb begin
    next_prevSwitch = switchEnablePin;
    next_prevChip = chipEnablePin;
    next_toggleSeen = (switchEnablePin ^ prevSwitch) | (chipEnablePin ^ prevChip);
  end

  // reset takes the pin levels so release itself is not seen as a toggle
  always_ff @(posedge clock) begin
    if (reset) begin
      prevSwitch <= switchEnablePin;
      prevChip <= chipEnablePin;
      toggleSeen <= 1'b0;
    end else begin
      prevSwitch <= next_prevSwitch;
      prevChip <= next_prevChip;
      toggleSeen <= next_toggleSeen;
    end
  end
endmodule
`default_nettype wire

// file: design/hbfrs_top.sv
// high bus fault response selector: registers, channels and outputs
`timescale 1ns/1ps
`default_nettype none
`include "hbfrs_defs.svh"
module hbfrs_top import hbfrs_pkg::*; #(
  parameter logic [`HBFRS_TIMER_W-1:0] HICCUP_CYCLES = `HBFRS_HICCUP_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register access
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  // second-level comparator outputs
  input wire logic faultOutUv,
  input wire logic faultInOv,
  input wire logic faultInUv,
  // strap and enable pins
  input wire logic [1:0] modeStrap,
  input wire logic switchEnablePin,
  input wire logic chipEnablePin,
  // responses
  output logic faultAlertN,
  output logic pwmEnable
);
  logic [7:0] ctrlReg;
  logic globalEnable;
  logic [2:0] statusBits;
  logic [1:0] strapMode;
  logic [1:0] next_strapMode;
  logic [7:0] next_ctrlReg;
  logic next_globalEnable;
  logic [2:0] next_statusBits;
  logic [7:0] next_regReadData;
  logic next_faultAlertN;
  logic next_pwmEnable;
  logic [2:0] faultVec;
  logic [5:0] fieldVec;
  logic [5:0] effMode;
  logic [2:0] stopVec;
  hbfrs_state_t chanState [3];
  logic toggleSeen;

  assign faultVec = {faultInUv, faultInOv, faultOutUv};
  assign fieldVec = ctrlReg[`HBFRS_CTRL_INUV_LSB+1:`HBFRS_CTRL_OUTUV_LSB];

  // register file: control byte, global enable bit, sticky status
  always_comb begin
    next_ctrlReg = ctrlReg;
    next_globalEnable = globalEnable;
    if (regWrite && regAddr == `HBFRS_ADDR_CTRL) next_ctrlReg = regWriteData;
    if (regWrite && regAddr == `HBFRS_ADDR_GLOBAL) begin
      next_globalEnable = regWriteData[`HBFRS_GLOBAL_EN_BIT];
    end
    // no clear path here, so a new fault can never be lost to a clear
    next_statusBits = statusBits | faultVec;
    next_regReadData = `HBFRS_RESET_BYTE;
    case (regAddr)
      `HBFRS_ADDR_CTRL: next_regReadData = ctrlReg;
      `HBFRS_ADDR_GLOBAL: next_regReadData[`HBFRS_GLOBAL_EN_BIT] = globalEnable;
      `HBFRS_ADDR_STATUS: begin
        next_regReadData[`HBFRS_STAT_INUV_BIT:`HBFRS_STAT_OUTUV_BIT] = statusBits;
      end
      default: next_regReadData = `HBFRS_RESET_BYTE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ctrlReg <= `HBFRS_RESET_BYTE;
      globalEnable <= 1'b0;
      statusBits <= 3'h0;
      regReadData <= `HBFRS_RESET_BYTE;
    end else begin
      ctrlReg <= next_ctrlReg;
      globalEnable <= next_globalEnable;
      statusBits <= next_statusBits;
      regReadData <= next_regReadData;
    end
  end

  // strap is sampled while reset is held; later pin changes are ignored
  always_comb begin
    next_strapMode = reset ? modeStrap : strapMode;
  end

  always_ff @(posedge clock) begin
    strapMode <= next_strapMode;
  end

  hbfrs_toggle_sense toggleSense (
    .clock(clock),
    .reset(reset),
    .switchEnablePin(switchEnablePin),
    .chipEnablePin(chipEnablePin),
    .toggleSeen(toggleSeen)
  );

  // channel 0 output undervoltage, 1 input overvoltage, 2 input undervoltage
  for (genvar i = 0; i < 3; i++) begin : gChan
    logic [`HBFRS_TIMER_W-1:0] quietCnt;
    logic [`HBFRS_TIMER_W-1:0] next_quietCnt;
    assign effMode[2*i+1:2*i] = globalEnable ? fieldVec[2*i+1:2*i] : strapMode;
    hbfrs_fault_channel #(.HICCUP_CYCLES(HICCUP_CYCLES)) chan (
      .clock(clock),
      .reset(reset),
      .faultIn(faultVec[i]),
      .respMode(effMode[2*i+1:2*i]),
      .toggleSeen(toggleSeen),
      .stopNext(stopVec[i]),
      .state(chanState[i])
    );

    // checker helper only: edges since the fault was last high, held at the delay
    always_comb begin
      next_quietCnt = quietCnt;
      if (faultVec[i]) begin
        next_quietCnt = `HBFRS_TIMER_ZERO;
      end else if (quietCnt != HICCUP_CYCLES) begin
        next_quietCnt = quietCnt + `HBFRS_TIMER_ONE;
      end
    end

    always_ff @(posedge clock) begin
      if (reset) begin
        quietCnt <= `HBFRS_TIMER_ZERO;
      end else begin
        quietCnt <= next_quietCnt;
      end
    end

    a_hiccup_not_early: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_WAIT) |=>
      (chanState[i] != HBFRS_IDLE || quietCnt == HICCUP_CYCLES))
      else $error("hiccup restarted before the delay");

    a_hiccup_on_time: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_WAIT && !faultVec[i] && quietCnt == HICCUP_CYCLES) |=>
      chanState[i] == HBFRS_IDLE)
      else $error("hiccup did not restart on time");

    a_latch_release: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_LATCHED && toggleSeen && !faultVec[i]) |=>
      chanState[i] == HBFRS_IDLE)
      else $error("latch-off not released by an enable toggle");

    a_latch_fault_stays: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_LATCHED && faultVec[i]) |=> chanState[i] == HBFRS_LATCHED)
      else $error("latch-off released while the fault was present");

    a_stop_onset: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_IDLE && faultVec[i] && effMode[2*i+1] != effMode[2*i]) |=>
      (!pwmEnable && !faultAlertN && statusBits[i]))
      else $error("stop not aligned with status and alert");

    a_flag_onset: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] == HBFRS_IDLE && faultVec[i] && effMode[2*i+1] == effMode[2*i]) |=>
      chanState[i] == HBFRS_IDLE)
      else $error("flag-only fault started a stop");

    a_status_by_fault: assert property (@(posedge clock) disable iff (reset)
      (!statusBits[i] && !faultVec[i]) |=> !statusBits[i])
      else $error("status bit set without its fault");

    a_stopped_while_busy: assert property (@(posedge clock) disable iff (reset)
      (chanState[i] != HBFRS_IDLE) |-> !pwmEnable)
      else $error("switching ran while a channel was stopped");
  end

  // alert follows the live fault; status keeps the history
  always_comb begin
    next_faultAlertN = ~(|faultVec);
    next_pwmEnable = ~(|stopVec);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      faultAlertN <= 1'b1;
      pwmEnable <= 1'b1;
    end else begin
      faultAlertN <= next_faultAlertN;
      pwmEnable <= next_pwmEnable;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence outUvStopOnset;
    faultOutUv && chanState[0] == HBFRS_IDLE && effMode[1:0] == HBFRS_HICCUP;
  endsequence

  sequence inUvLatchOnset;
    faultInUv && chanState[2] == HBFRS_IDLE && effMode[5:4] == HBFRS_LATCH;
  endsequence

  sequence inOvLatchOnset;
    faultInOv && chanState[1] == HBFRS_IDLE && effMode[3:2] == HBFRS_LATCH;
  endsequence

  sequence inOvClearInHold;
    chanState[1] == HBFRS_HOLD && !faultInOv;
  endsequence

  sequence ctrlWrite;
    regWrite && regAddr == `HBFRS_ADDR_CTRL;
  endsequence

  sequence ctrlAddrHeld;
    regAddr == `HBFRS_ADDR_CTRL;
  endsequence

  a_status_outuv: assert property (faultOutUv |=> statusBits[0])
    else $error("output undervoltage status not set");

  a_status_inov: assert property (faultInOv |=> statusBits[1])
    else $error("input overvoltage status not set");

  a_status_inuv: assert property (faultInUv |=> statusBits[2])
    else $error("input undervoltage status not set");

  a_status_sticky: assert property ((statusBits != 3'h0) |=>
    (statusBits & $past(statusBits)) == $past(statusBits))
    else $error("status bit cleared by itself");

  a_alert_low: assert property ((|faultVec) |=> !faultAlertN)
    else $error("alert not driven low on fault");

  a_stop_together: assert property (outUvStopOnset |=>
    !pwmEnable && !faultAlertN && statusBits[0])
    else $error("hiccup stop not aligned with flag and alert");

  a_latch_stop: assert property (inUvLatchOnset |=> !pwmEnable [*2])
    else $error("latch-off did not hold switching stopped");

  a_mode_field: assert property ((globalEnable && regWrite &&
    regAddr == `HBFRS_ADDR_CTRL) |=> effMode == $past(regWriteData[7:2]))
    else $error("response not taken from control field");

  a_mode_strap: assert property ((!globalEnable && !regWrite) |=>
    effMode == {3{strapMode}})
    else $error("strap response not used while fields disabled");

  a_flag_runs: assert property ((chanState[0] == HBFRS_IDLE &&
    chanState[1] == HBFRS_IDLE && chanState[2] == HBFRS_IDLE &&
    effMode[0] == effMode[1] && effMode[2] == effMode[3] && effMode[4] == effMode[5])
    |=> pwmEnable)
    else $error("flag-only fault stopped switching");

  a_alert_release: assert property ((faultVec == 3'h0) |=> faultAlertN)
    else $error("alert held low with no fault");

  a_latch_alert_stop: assert property (inOvLatchOnset |=>
    !pwmEnable && !faultAlertN && statusBits[1])
    else $error("latch-off stop not aligned with flag and alert");

  a_hiccup_wait_stop: assert property (inOvClearInHold |=> !pwmEnable [*2])
    else $error("hiccup restarted as soon as the fault cleared");

  a_global_store: assert property ((regWrite &&
    regAddr == `HBFRS_ADDR_GLOBAL) |=>
    globalEnable == $past(regWriteData[`HBFRS_GLOBAL_EN_BIT]))
    else $error("global enable not stored");

  a_ctrl_readback: assert property (ctrlWrite ##1 ctrlAddrHeld |=>
    regReadData == $past(regWriteData, 2))
    else $error("control byte not read back as written");

  a_ctrl_hold: assert property (!(regWrite && regAddr == `HBFRS_ADDR_CTRL) |=>
    $stable(ctrlReg))
    else $error("control byte changed without a write");

  a_status_read: assert property ((regAddr == `HBFRS_ADDR_STATUS) |=>
    regReadData[`HBFRS_STAT_INUV_BIT:`HBFRS_STAT_OUTUV_BIT] == $past(statusBits) &&
    regReadData[`HBFRS_STAT_OUTUV_BIT-1:0] == 5'h00)
    else $error("status register read wrong");

  a_global_read: assert property ((regAddr == `HBFRS_ADDR_GLOBAL) |=>
    regReadData[`HBFRS_GLOBAL_EN_BIT] == $past(globalEnable))
    else $error("global enable read wrong");

  a_field_ignored: assert property ((!globalEnable && regWrite &&
    regAddr == `HBFRS_ADDR_CTRL) |=> $stable(effMode))
    else $error("control field used while fields disabled");

  a_strap_hold: assert property ($stable(strapMode))
    else $error("strapped mode changed outside reset");
endmodule
`default_nettype wire

// file: inc/hbfrs_defs.svh
// constants for the high bus fault response selector
`ifndef HBFRS_DEFS_SVH
`define HBFRS_DEFS_SVH
`define HBFRS_ADDR_GLOBAL 8'hB0
`define HBFRS_ADDR_CTRL 8'hB8
`define HBFRS_ADDR_STATUS 8'hD7
`define HBFRS_GLOBAL_EN_BIT 7
`define HBFRS_CTRL_OUTUV_LSB 2
`define HBFRS_CTRL_INOV_LSB 4
`define HBFRS_CTRL_INUV_LSB 6
`define HBFRS_STAT_OUTUV_BIT 5
`define HBFRS_STAT_INOV_BIT 6
`define HBFRS_STAT_INUV_BIT 7
`define HBFRS_RESET_BYTE 8'h00
`define HBFRS_RESET_STRAP 2'h0
`define HBFRS_HICCUP_MS 500
`define HBFRS_CLOCK_KHZ 50000
`define HBFRS_HICCUP_CYCLES (`HBFRS_TIMER_W'(`HBFRS_HICCUP_MS * `HBFRS_CLOCK_KHZ))
`define HBFRS_TIMER_W 25
`define HBFRS_TIMER_ZERO 25'h0000000
`define HBFRS_TIMER_ONE 25'h0000001
`endif

// file: inc/hbfrs_pkg.sv
// types shared by the fault response selector modules
`default_nettype none
package hbfrs_pkg;
  typedef enum logic [1:0] {
    HBFRS_FLAG = 2'h0,
    HBFRS_HICCUP = 2'h1,
    HBFRS_LATCH = 2'h2,
    HBFRS_FLAG_ALT = 2'h3
  } hbfrs_resp_t;
  typedef enum logic [3:0] {
    HBFRS_IDLE = 4'h1,
    HBFRS_HOLD = 4'h2,
    HBFRS_WAIT = 4'h4,
    HBFRS_LATCHED = 4'h8
  } hbfrs_state_t;
endpackage
`default_nettype wire

// file: sim/hbfrs_host_model.sv
// host controller model: register writes and enable pin toggles
`timescale 1ns/1ps
`default_nettype none
module hbfrs_host_model (
  // clock
  input wire logic clock,
  // register port
  output logic regWrite,
  output logic [7:0] regAddr,
  output logic [7:0] regWriteData,
  // enable pins
  output logic switchEnablePin,
  output logic chipEnablePin
);
  initial begin
    regWrite = 1'b0;
    regAddr = 8'h00;
    regWriteData = 8'hFF;
    switchEnablePin = 1'b1;
    chipEnablePin = 1'b1;
  end
  // data lines show the inverse once released, so stale data cannot pass
  task automatic writeReg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clock);
    regAddr = addr;
    regWriteData = data;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    regWriteData = ~data;
  endtask
  task automatic setAddr(input logic [7:0] addr);
    @(negedge clock);
    regAddr = addr;
  endtask
  // only called once the fault has gone away
  task automatic togglePin(input logic useChip);
    @(negedge clock);
    if (useChip) chipEnablePin = ~chipEnablePin;
    else switchEnablePin = ~switchEnablePin;
  endtask
endmodule
`default_nettype wire

// file: sim/hbfrs_top_bench.sv
// self-checking bench for the fault response selector
`timescale 1ns/1ps
`default_nettype none
`include "hbfrs_defs.svh"
module hbfrs_top_bench;
  // short hiccup delay keeps the run brief
  localparam int HIC = 20;
  logic clock, reset, regWrite, faultAlertN, pwmEnable, swPin, cePin;
  logic [7:0] regAddr, regWriteData, regReadData, ctrl, expStatus, addr;
  logic [7:0] probe [4];
  logic [1:0] modeStrap;
  logic [2:0] fault;
  logic [8:0] q[$];
  logic [8:0] n;
  logic stops;
  int errorCnt = 0, numChecks = 0, seed = 95455;
  event resultReady;
  hbfrs_top #(.HICCUP_CYCLES(25'(HIC))) hbfrs_top_inst (
    .clock(clock), .reset(reset), .regWrite(regWrite), .regAddr(regAddr),
    .regWriteData(regWriteData), .regReadData(regReadData), .faultOutUv(fault[0]),
    .faultInOv(fault[1]), .faultInUv(fault[2]), .modeStrap(modeStrap),
    .switchEnablePin(swPin), .chipEnablePin(cePin), .faultAlertN(faultAlertN),
    .pwmEnable(pwmEnable));
  hbfrs_host_model hbfrs_host_model_inst (
    .clock(clock), .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
    .switchEnablePin(swPin), .chipEnablePin(cePin));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic printVerdict();
    $display("errors %0d checks %0d", errorCnt, numChecks);
    if (errorCnt == 0 && numChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmpOut(input logic [1:0] e);
    numChecks++;
    if ({faultAlertN, pwmEnable} !== e) begin
      errorCnt++;
      $display("MISMATCH t=%0t alert,pwm %b exp %b", $time, {faultAlertN, pwmEnable}, e);
    end
  endtask
  task automatic cmpRead(input logic [7:0] e);
    numChecks++;
    if (regReadData !== e) begin
      errorCnt++;
      $display("MISMATCH t=%0t read %h exp %h", $time, regReadData, e);
    end
  endtask
  // one note per sampling point, so no trigger is lost
  task automatic note(input logic kind, input logic [7:0] v);
    q.push_back({kind, v});
    ->resultReady;
  endtask
  task automatic waitNeg(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic readReg(input logic [7:0] a, input logic [7:0] e);
    hbfrs_host_model_inst.setAddr(a);
    @(negedge clock);
    note(1'b1, e);
  endtask
  task automatic doReset(input logic [1:0] strap);
    reset = 1'b1;
    modeStrap = strap;
    waitNeg(5);
    reset = 1'b0;
  endtask
  initial begin
    forever begin
      @(resultReady);
      n = q.pop_front();
      if (n[8]) cmpRead(n[7:0]);
      else cmpOut(n[1:0]);
    end
  end
  initial begin
    #(20 * 4000);
    errorCnt++;
    printVerdict();
  end
  initial begin
    fault = 3'h0;
    doReset(2'h0);
    note(1'b0, 8'h03);
    do addr = 8'($random(seed));
    while (addr == 8'hB0 || addr == 8'hB8 || addr == 8'hD7);
    probe = '{`HBFRS_ADDR_CTRL, `HBFRS_ADDR_GLOBAL, `HBFRS_ADDR_STATUS, addr};
    foreach (probe[i]) readReg(probe[i], 8'h00);
    hbfrs_host_model_inst.writeReg(`HBFRS_ADDR_GLOBAL, 8'hFF);
    readReg(`HBFRS_ADDR_GLOBAL, 8'h80);
    expStatus = 8'h00;
    for (int ch = 0; ch < 3; ch++) begin
      for (int code = 0; code < 4; code++) begin
        ctrl = 8'($random(seed));
        ctrl[2 * ch + 2 +: 2] = 2'(code);
        stops = (code == 1) || (code == 2);
        hbfrs_host_model_inst.writeReg(`HBFRS_ADDR_CTRL, ctrl);
        readReg(`HBFRS_ADDR_CTRL, ctrl);
        fault[ch] = 1'b1;
        @(negedge clock);
        note(1'b0, {7'h00, !stops});
        expStatus[5 + ch] = 1'b1;
        readReg(`HBFRS_ADDR_STATUS, expStatus);
        fault[ch] = 1'b0;
        @(negedge clock);
        note(1'b0, {7'h01, !stops});
        if (code == 1) begin
          waitNeg(HIC - 1);
          note(1'b0, 8'h02);
          @(negedge clock);
          note(1'b0, 8'h03);
        end else if (code == 2) begin
          waitNeg(HIC + 2);
          note(1'b0, 8'h02);
          hbfrs_host_model_inst.togglePin(1'(ch));
          waitNeg(2);
          note(1'b0, 8'h03);
        end
      end
    end
    // status is read only and stays set after the faults clear
    hbfrs_host_model_inst.writeReg(`HBFRS_ADDR_STATUS, 8'h00);
    readReg(`HBFRS_ADDR_STATUS, 8'hE0);
    doReset(2'h1);
    hbfrs_host_model_inst.writeReg(`HBFRS_ADDR_CTRL, 8'hFF);
    fault[2] = 1'b1;
    @(negedge clock);
    note(1'b0, 8'h00);
    fault[2] = 1'b0;
    waitNeg(HIC + 1);
    note(1'b0, 8'h03);
    waitNeg(2);
    printVerdict();
  end
endmodule
`default_nettype wire
